//--- src/bfs_pkg.sv
// Purpose: shared constants and types for the boost fault and sync control block
// Assumes: 100 MHz sys_clk
// Notes: times are kept in their own unit and turned into cycle counts here
package bfs_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   // under-voltage timeout, in ms
   localparam int unsigned UV_TIMEOUT_MS = 110;
   localparam longint unsigned UV_TIMEOUT_CYC = longint'(UV_TIMEOUT_MS) * CLK_HZ / 1000;
   // output discharge interval, in ms
   localparam int unsigned DISCH_MS = 400;
   localparam longint unsigned DISCH_CYC = longint'(DISCH_MS) * CLK_HZ / 1000;
   // accepted sync clock band, in kHz
   localparam int unsigned SYNC_MIN_KHZ = 100;
   localparam int unsigned SYNC_MAX_KHZ = 2222;
   // longest and shortest accepted sync period in cycles
   localparam int unsigned SYNC_MAX_PER = CLK_HZ / (SYNC_MIN_KHZ * 1000);
   localparam int unsigned SYNC_MIN_PER = (CLK_HZ + SYNC_MAX_KHZ * 1000 - 1) / (SYNC_MAX_KHZ * 1000);
   // edges in a row needed before the sync clock is trusted
   localparam int unsigned SYNC_LOCK_EDGES = 4;
   // spread settings reset values
   localparam logic [1:0] SPREAD_RANGE_RST = 2'h2;
   localparam logic [1:0] DITHER_RATE_RST = 2'h0;
   // deviation in tenths of a percent and modulation rate in Hz
   localparam logic [6:0] DEV_TENTHS [4] = '{7'h21, 7'h2B, 7'h35, 7'h48};
   localparam logic [10:0] MOD_HZ [4] = '{11'h0C8, 11'h1F4, 11'h320, 11'h4B0};

   typedef enum logic [1:0]
   {
      BFS_CLK_INT_FIXED = 2'b00,
      BFS_CLK_INT_SPREAD = 2'b01,
      BFS_CLK_EXT_SYNC = 2'b10
   } bfs_clk_mode_t;

   typedef enum logic [1:0]
   {
      BFS_ST_RUN = 2'b00,
      BFS_ST_DISCHARGE = 2'b01,
      BFS_ST_OFF = 2'b10
   } bfs_state_t;
endpackage : bfs_pkg

//--- src/bfs_sync_if.sv
// Purpose: carries sync detector results to the top module
// Assumes: single clock domain
// Notes: detector drives, controller reads
`timescale 1ns/100ps
interface bfs_sync_if;
   logic ext_clk_ok;
   logic ext_edge;
   logic pin_level;
   modport det
   (
      output ext_clk_ok,
      output ext_edge,
      output pin_level
   );
   modport ctl
   (
      input ext_clk_ok,
      input ext_edge,
      input pin_level
   );
endinterface : bfs_sync_if

//--- src/bfs_sync_detect.sv
// Purpose: detects an external clock on the boost clock select pin
// Assumes: pin already synchronous to sys_clk
// Notes: a period outside the band drops the lock at once
`timescale 1ns/100ps
module bfs_sync_detect
   import bfs_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // pin
   input wire logic boost_clock_select_pin,
   // results
   bfs_sync_if.det sync
);
   localparam int CW = $clog2(SYNC_MAX_PER + 2);
   logic pin_ff;
   logic [CW-1:0] per_ff;
   logic [2:0] good_ff;
   logic rise;
   assign rise = boost_clock_select_pin & ~pin_ff;

   // previous pin level for edge finding
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) pin_ff <= 1'b0;
      else pin_ff <= boost_clock_select_pin;
   end

   // period counter, saturates so a static pin reads as no clock
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) per_ff <= '0;
      else if (rise) per_ff <= CW'(1);
      else if (per_ff <= CW'(SYNC_MAX_PER)) per_ff <= per_ff + CW'(1);
   end

   // count good periods, lock after several in a row
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) good_ff <= '0;
      else if (per_ff > CW'(SYNC_MAX_PER)) good_ff <= '0;
      else if (rise && per_ff != '0)
      begin
         if (per_ff < CW'(SYNC_MIN_PER)) good_ff <= '0;
         else if (good_ff != 3'(SYNC_LOCK_EDGES)) good_ff <= good_ff + 3'h1;
      end
   end

   assign sync.ext_clk_ok = (good_ff == 3'(SYNC_LOCK_EDGES));
   assign sync.ext_edge = rise;
   assign sync.pin_level = pin_ff;
endmodule : bfs_sync_detect

//--- src/bfs_control.sv
// Purpose: fault supervision, boost clock mode, spread coding and discharge timing
// Assumes: comparator inputs are synchronous levels; rst_b is independent of the enable pin
// Notes: enable_in low starts the discharge; rst_b only for power-up
// Overview of operation
// R1: lower overvolt halts switching, sinks stay on
// R2: upper overvolt enters fault recovery, sets flag
// R3: undervolt timeout expiry enters recovery, sets flag
// R4: undervolt recovery clears timer, no flag
// R5: static sync pin high enables spreading
// R6: valid sync clock selects external mode, no spread
// R7: lost sync clock falls back to internal
// R8: spread range code maps deviation, default 10
// R9: dither rate code maps rate, default 00
// R10: enable low stops boost, sinks, FET; discharges
// R11: discharge lasts fixed interval then shutdown
// R12: discharge pin comparator forces recovery and flag
// R13: board ties discharge pin to boost output
// R14: sync clock detected at start, else internal
`timescale 1ns/100ps
module bfs_control
   import bfs_pkg::*;
#(
   parameter longint unsigned UV_CYCLES = UV_TIMEOUT_CYC,
   parameter longint unsigned DISCH_CYCLES = DISCH_CYC
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // enable and pins
   input wire logic enable_in,
   input wire logic boost_clock_select_pin,
   // comparator levels
   input wire logic overvolt_lower_level,
   input wire logic overvolt_upper_level,
   input wire logic undervolt_level,
   input wire logic upper_overvolt_fault,
   // spread settings and flag clear
   input wire logic [1:0] spread_range_sel,
   input wire logic [1:0] dither_rate_sel,
   input wire logic settings_we,
   input wire logic flags_clear,
   // controls to the power stage
   output logic boost_switch_en,
   output logic sinks_en,
   output logic power_fet_en,
   output logic discharge_en,
   output logic fault_recovery,
   output logic shutdown,
   // clocking
   output bfs_clk_mode_t clk_mode,
   output logic ext_clk_edge,
   output logic [6:0] spread_dev_tenths,
   output logic [10:0] dither_rate_hz,
   // status
   output logic overvolt_low_flag,
   output logic overvolt_high_flag,
   output logic overcurrent_timeout_flag
);
   localparam int UW = $clog2(UV_CYCLES + 1);
   localparam int DW = $clog2(DISCH_CYCLES + 1);

   bfs_sync_if sync();
   bfs_state_t state_ff, nxt_state;
   logic [UW-1:0] uv_cnt_ff;
   logic [DW-1:0] dis_cnt_ff;
   logic [1:0] range_ff, rate_ff;
   logic recov_ff;
   logic uv_expire;
   logic running;

   bfs_sync_detect u_sync
   (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .boost_clock_select_pin(boost_clock_select_pin),
      .sync(sync)
   );

   assign running = (state_ff == BFS_ST_RUN);
   assign uv_expire = running && undervolt_level && (uv_cnt_ff == UW'(UV_CYCLES - 1));

   // R10 enable removal
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         BFS_ST_RUN: if (!enable_in) nxt_state = BFS_ST_DISCHARGE;
         BFS_ST_DISCHARGE:
            // R11 timed then shutdown
            if (dis_cnt_ff == DW'(DISCH_CYCLES - 1)) nxt_state = BFS_ST_OFF;
         BFS_ST_OFF: if (enable_in) nxt_state = BFS_ST_RUN;
         default: nxt_state = BFS_ST_RUN;
      endcase
   end

   // sequence state
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) state_ff <= BFS_ST_RUN;
      else state_ff <= nxt_state;
   end

   // discharge interval counter
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) dis_cnt_ff <= '0;
      else if (state_ff == BFS_ST_DISCHARGE) dis_cnt_ff <= dis_cnt_ff + DW'(1);
      else dis_cnt_ff <= '0;
   end

   // R3 timeout counter runs while under-voltage stands
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) uv_cnt_ff <= '0;
      // R4 recovery clears counter
      else if (!undervolt_level || !running || recov_ff) uv_cnt_ff <= '0;
      else if (!uv_expire) uv_cnt_ff <= uv_cnt_ff + UW'(1);
   end

   // recovery holds until software clears or the run state ends; set wins over clear
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b) recov_ff <= 1'b0;
      // R2 R12 upper fault into recovery
      else if (running && (overvolt_upper_level || upper_overvolt_fault || uv_expire))
         recov_ff <= 1'b1;
      else if (flags_clear || !running) recov_ff <= 1'b0;
   end

   // sticky status flags, set beats clear
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         overvolt_low_flag <= 1'b0;
         overvolt_high_flag <= 1'b0;
         overcurrent_timeout_flag <= 1'b0;
      end
      else
      begin
         // R1 lower overvolt flag
         if (running && overvolt_lower_level) overvolt_low_flag <= 1'b1;
         else if (flags_clear) overvolt_low_flag <= 1'b0;
         // R12 discharge comparator reports too
         if (running && (overvolt_upper_level || upper_overvolt_fault))
            overvolt_high_flag <= 1'b1;
         else if (flags_clear) overvolt_high_flag <= 1'b0;
         // R3 timeout flag
         if (uv_expire) overcurrent_timeout_flag <= 1'b1;
         else if (flags_clear) overcurrent_timeout_flag <= 1'b0;
      end
   end

   // spread settings, loaded by strobe
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         // R8 R9 reset defaults
         range_ff <= SPREAD_RANGE_RST;
         rate_ff <= DITHER_RATE_RST;
      end
      else if (settings_we)
      begin
         range_ff <= spread_range_sel;
         rate_ff <= dither_rate_sel;
      end
   end

   // registered clock mode and coded outputs
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         clk_mode <= BFS_CLK_INT_FIXED;
         spread_dev_tenths <= '0;
         dither_rate_hz <= '0;
      end
      // R6 R14 external clock wins; R7 R5 else static level
      else if (sync.ext_clk_ok)
      begin
         clk_mode <= BFS_CLK_EXT_SYNC;
         spread_dev_tenths <= '0;
         dither_rate_hz <= '0;
      end
      else
      begin
         clk_mode <= sync.pin_level ? BFS_CLK_INT_SPREAD : BFS_CLK_INT_FIXED;
         // R8 R9 code tables
         spread_dev_tenths <= sync.pin_level ? DEV_TENTHS[range_ff] : '0;
         dither_rate_hz <= sync.pin_level ? MOD_HZ[rate_ff] : '0;
      end
   end

   // power stage controls; lower overvolt only pauses boost switching
   assign ext_clk_edge = sync.ext_clk_ok & sync.ext_edge;
   // R1 halt switching only
   assign boost_switch_en = running && !recov_ff && !overvolt_lower_level;
   assign sinks_en = running && !recov_ff;
   assign power_fet_en = running;
   assign discharge_en = (state_ff == BFS_ST_DISCHARGE);
   assign fault_recovery = recov_ff;
   assign shutdown = (state_ff == BFS_ST_OFF);

   // R1 switching stops with lower overvolt
   a_ovl_halt: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
      overvolt_lower_level |-> !boost_switch_en) else $error("switching during overvolt");
   // R2 upper fault enters recovery
   a_ovh_recov: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
      running && overvolt_upper_level |=> recov_ff && overvolt_high_flag)
      else $error("no recovery on upper overvolt");
   // R3 expiry flags
   a_uv_expiry: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
      uv_expire |=> overcurrent_timeout_flag && recov_ff) else $error("timeout lost");
   // R4 counter cleared
   a_uv_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
      !undervolt_level |=> uv_cnt_ff == '0) else $error("uv counter not cleared");
   // R6 lock selects external mode with no spread
   a_ext_nospread: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
      sync.ext_clk_ok |=> clk_mode == BFS_CLK_EXT_SYNC && spread_dev_tenths == '0)
      else $error("spread in external mode");
   // R5 static high spreads
   a_static_spread: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
      !sync.ext_clk_ok && sync.pin_level |=> clk_mode == BFS_CLK_INT_SPREAD)
      else $error("spread not enabled");
   // R10 disable stops stage
   sequence s_disable;
      running && !enable_in;
   endsequence
   a_en_stop: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
      s_disable |=> discharge_en && !power_fet_en && !sinks_en && !boost_switch_en)
      else $error("stage not stopped");
   // R11 no early shutdown
   a_dis_time: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
      $rose(shutdown) |-> $past(dis_cnt_ff) == DW'(DISCH_CYCLES - 1))
      else $error("early shutdown");
   // R12 discharge comparator
   a_dis_ovh: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
      running && upper_overvolt_fault |=> recov_ff && overvolt_high_flag)
      else $error("backup comparator ignored");
endmodule : bfs_control

//--- test/bfs_stage_model.sv
// Purpose: behavioural boost power stage and sync source facing the control block
// Assumes: 100 MHz sys_clk, bench requests the output conditions
// Notes: the sync clock runs only while a period is requested
`timescale 1ns/100ps
module bfs_stage_model
(
   // clock
   input wire logic sys_clk,
   // bench requests: cond bit 0 lower ov, 1 upper ov, 2 under-volt, 3 output far too high
   input wire logic [7:0] sync_per,
   input wire logic sync_lvl,
   input wire logic [3:0] cond,
   // to the control block
   output logic sync_pin,
   output logic ovl,
   output logic ovh,
   output logic uv,
   output logic disch_hi
);
   logic [7:0] cnt_ff = 8'h00;
   initial sync_pin = 1'b0;
   // clock stands at the static level between bursts, never left at a stale phase
   always @(posedge sys_clk)
   begin
      cnt_ff <= #1 (cnt_ff + 8'h01 >= sync_per) ? 8'h00 : cnt_ff + 8'h01;
      sync_pin <= #1 (sync_per == 8'h00) ? sync_lvl : (cnt_ff < sync_per / 2);
   end
   // comparators see the one boost output
   assign ovl = cond[0];
   assign ovh = cond[1];
   assign uv = cond[2];
   assign disch_hi = cond[3];
endmodule : bfs_stage_model

//--- test/boost_fault_sync_control_tb.sv
// Purpose: self-checking bench for the boost fault and sync control block
// Assumes: short timeout and discharge counts set by parameter
// Notes: inputs move 1 ns after the rising edge, outputs are read there too
`timescale 1ns/100ps
module boost_fault_sync_control_tb;
   import bfs_pkg::*;
   localparam int UVC = 20;
   localparam int DC = 30;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic enable_in = 1'b1;
   logic [1:0] rng = 2'h0;
   logic [1:0] rate = 2'h0;
   logic we = 1'b0;
   logic clr = 1'b0;
   logic [7:0] per = 8'h00;
   logic lvl = 1'b0;
   logic [3:0] cond = 4'h0;
   logic pin, ovl, ovh, uv, dhi, sw, snk, fet, dis, rec, sd, fl, fh, fo, edg;
   bfs_clk_mode_t mode;
   logic [6:0] dev;
   logic [10:0] hz;
   logic [6:0] dv [4] = '{7'h21, 7'h2B, 7'h35, 7'h48};
   logic [10:0] mh [4] = '{11'h0C8, 11'h1F4, 11'h320, 11'h4B0};
   int n_errors = 0;
   int comparisons = 0;
   int n;
   always #5 sys_clk = ~sys_clk;
   bfs_stage_model stage (.sys_clk(sys_clk), .sync_per(per), .sync_lvl(lvl), .cond(cond),
      .sync_pin(pin), .ovl(ovl), .ovh(ovh), .uv(uv), .disch_hi(dhi));
   bfs_control #(.UV_CYCLES(UVC), .DISCH_CYCLES(DC)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
      .enable_in(enable_in), .boost_clock_select_pin(pin), .overvolt_lower_level(ovl),
      .overvolt_upper_level(ovh), .undervolt_level(uv), .upper_overvolt_fault(dhi),
      .spread_range_sel(rng), .dither_rate_sel(rate), .settings_we(we), .flags_clear(clr),
      .boost_switch_en(sw), .sinks_en(snk), .power_fet_en(fet), .discharge_en(dis),
      .fault_recovery(rec), .shutdown(sd), .clk_mode(mode), .ext_clk_edge(edg),
      .spread_dev_tenths(dev), .dither_rate_hz(hz), .overvolt_low_flag(fl),
      .overvolt_high_flag(fh), .overcurrent_timeout_flag(fo));
   // step whole cycles, then settle past the edge
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic setc(input logic [1:0] r, input logic [1:0] m);
      rng = r;
      rate = m;
      we = 1'b1;
      tick(1);
      we = 1'b0;
      tick(2);
   endtask : setc
   task automatic clear_flags();
      cond = 4'h0;
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(2);
   endtask : clear_flags
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   // hang guard, far beyond the under two thousand cycles the tests need
   initial
   begin
      #100us;
      n_errors++;
      give_verdict();
   end
   initial
   begin
      tick(4);
      rst_b = 1'b1;
      tick(2);
      chk("mode", 11'(BFS_CLK_INT_FIXED), 11'(mode));
      chk("fet", 11'h001, 11'(fet));
      chk("flags", 11'h000, 11'({fl, fh, fo}));
      $display("test reset done");
      lvl = 1'b1;
      tick(4);
      chk("mode", 11'(BFS_CLK_INT_SPREAD), 11'(mode));
      chk("dev", 11'(dv[2]), 11'(dev));
      chk("hz", mh[0], hz);
      for (int i = 0; i < 4; i++)
      begin
         setc(2'(i), 2'(3 - i));
         chk("dev", 11'(dv[i]), 11'(dev));
         chk("hz", mh[3 - i], hz);
      end
      lvl = 1'b0;
      tick(4);
      chk("mode", 11'(BFS_CLK_INT_FIXED), 11'(mode));
      chk("dev", 11'h000, 11'(dev));
      $display("test spread done");
      cond = 4'h1;
      tick(2);
      chk("switch", 11'h000, 11'(sw));
      chk("sinks", 11'h001, 11'(snk));
      chk("ovl flag", 11'h001, 11'(fl));
      cond = 4'h0;
      tick(2);
      chk("switch", 11'h001, 11'(sw));
      clear_flags();
      $display("test lower overvolt done");
      cond = 4'h4;
      tick(UVC - 5);
      cond = 4'h0;
      tick(UVC + 5);
      chk("oc flag", 11'h000, 11'(fo));
      chk("recovery", 11'h000, 11'(rec));
      cond = 4'h4;
      tick(UVC + 3);
      chk("oc flag", 11'h001, 11'(fo));
      chk("recovery", 11'h001, 11'(rec));
      clear_flags();
      chk("recovery", 11'h000, 11'(rec));
      $display("test undervolt done");
      for (int k = 0; k < 2; k++)
      begin
         cond = k ? 4'h8 : 4'h2;
         tick(2);
         chk("recovery", 11'h001, 11'(rec));
         chk("ovh flag", 11'h001, 11'(fh));
         chk("sinks", 11'h000, 11'(snk));
         clear_flags();
         chk("ovh flag", 11'h000, 11'(fh));
      end
      $display("test upper overvolt done");
      per = 8'd60;
      tick(7 * 60);
      chk("mode", 11'(BFS_CLK_EXT_SYNC), 11'(mode));
      chk("dev", 11'h000, 11'(dev));
      // edges are counted at the sampling edge, the pulse lasts one whole cycle
      n = 0;
      repeat (60)
      begin
         @(posedge sys_clk);
         n += int'(edg === 1'b1);
      end
      #1;
      chk("sync edges", 11'h001, 11'(n));
      per = 8'h00;
      lvl = 1'b1;
      // lock drops only once a full longest accepted period has gone by
      tick(1100);
      chk("mode", 11'(BFS_CLK_INT_SPREAD), 11'(mode));
      $display("test sync clock done");
      enable_in = 1'b0;
      tick(1);
      chk("stop", 11'h008, 11'({dis, fet, snk, sw}));
      n = 1;
      while (sd !== 1'b1 && n < DC + 10)
      begin
         tick(1);
         n++;
      end
      chk("shutdown", 11'h001, 11'(sd));
      chk("disch time", 11'(DC + 1), 11'(n));
      enable_in = 1'b1;
      tick(2);
      chk("fet", 11'h001, 11'(fet));
      $display("test discharge done");
      give_verdict();
   end
endmodule : boost_fault_sync_control_tb
